// ---- design/lsp_i2c_target.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsp_i2c_target #(
  parameter logic ADDR_VARIANT = 1'b0,
  parameter int TIMEOUT_CYC = lsp_pkg::LSP_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] light_result,
  input wire logic [15:0] ir_result,
  input wire logic result_valid,
  input wire logic [7:0] event_flags,
  output logic core_power_down,
  output logic channel_power_down,
  output logic bus_timeout
);
  import lsp_pkg::*;

  logic scl_d_reg, sda_d_reg;
  lsp_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic [7:0] cmd_reg, rd_byte;
  logic have_cmd_reg, rw_reg, byte_hi_reg;
  logic [7:0] conf_a_reg, conf_b_reg, wh_l_reg, wh_h_reg, wl_l_reg, wl_h_reg;
  logic [15:0] light_hold_reg, ir_hold_reg;
  logic [31:0] low_cnt_reg;

  wire scl_rise = scl_in & ~scl_d_reg;
  wire scl_fall = ~scl_in & scl_d_reg;
  wire start_cond = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
  wire stop_cond = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
  wire [6:0] my_addr = ADDR_VARIANT ? LSP_ADDR_B : LSP_ADDR_A;
  wire addr_match = shift_reg[7:1] == my_addr;
  wire shut_down = conf_a_reg[LSP_BIT_CORE_PD] | conf_b_reg[LSP_BIT_CHAN_PD];
  wire [7:0] wr_cmd = cmd_reg + {7'h00, byte_hi_reg};
  always_comb rd_byte = read_mux(wr_cmd);
  wire line_low = ~scl_in | ~sda_in;

  // Unmapped and reserved codes read as zero but still ack
  function automatic logic [7:0] read_mux(input logic [7:0] c);
    unique case (c)
      LSP_CMD_CONF_A: read_mux = conf_a_reg;
      LSP_CMD_CONF_B: read_mux = conf_b_reg;
      LSP_CMD_WH_L: read_mux = wh_l_reg;
      LSP_CMD_WH_H: read_mux = wh_h_reg;
      LSP_CMD_WL_L: read_mux = wl_l_reg;
      LSP_CMD_WL_H: read_mux = wl_h_reg;
      LSP_CMD_LIGHT_L: read_mux = light_hold_reg[7:0];
      LSP_CMD_LIGHT_H: read_mux = light_hold_reg[15:8];
      LSP_CMD_IR_L: read_mux = ir_hold_reg[7:0];
      LSP_CMD_IR_H: read_mux = ir_hold_reg[15:8];
      LSP_CMD_ID_L: read_mux = LSP_ID_LOW;
      LSP_CMD_ID_H: read_mux = LSP_ID_HIGH;
      LSP_CMD_EVENT: read_mux = event_flags;
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  // Timeout counts any low line; 25 ms floor sits inside the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 32'h0000_0000;
      bus_timeout <= 1'b0;
    end else if (!line_low) begin
      low_cnt_reg <= 32'h0000_0000;
      bus_timeout <= 1'b0;
    end else if (low_cnt_reg < 32'(TIMEOUT_CYC)) begin
      low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
    end else begin
      bus_timeout <= 1'b1;
    end
  end

  // Results captured only while running, so shutdown keeps the last one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      light_hold_reg <= 16'h0000;
      ir_hold_reg <= 16'h0000;
    end else if (result_valid && !shut_down) begin
      light_hold_reg <= light_result;
      ir_hold_reg <= ir_result;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_power_down <= 1'b1;
      channel_power_down <= 1'b0;
    end else begin
      core_power_down <= conf_a_reg[LSP_BIT_CORE_PD];
      channel_power_down <= conf_b_reg[LSP_BIT_CHAN_PD];
    end
  end

  wire wr_byte_done = (state_reg == LSP_WBYTE) && scl_fall && bit_reg == 4'h8;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LSP_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      cmd_reg <= 8'h00;
      have_cmd_reg <= 1'b0;
      rw_reg <= 1'b0;
      byte_hi_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      conf_a_reg <= LSP_CONF_A_RESET;
      conf_b_reg <= LSP_CONF_B_RESET;
      wh_l_reg <= 8'h00;
      wh_h_reg <= 8'h00;
      wl_l_reg <= 8'h00;
      wl_h_reg <= 8'h00;
    end else if (bus_timeout || stop_cond) begin
      state_reg <= LSP_IDLE;
      sda_oe <= 1'b0;
      have_cmd_reg <= 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the command code for the read
      state_reg <= LSP_ADDR;
      bit_reg <= 4'h0;
      byte_hi_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      unique case (state_reg)
        LSP_IDLE: sda_oe <= 1'b0;
        LSP_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_in};
            bit_reg <= bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            if (addr_match) begin
              rw_reg <= shift_reg[0];
              sda_oe <= 1'b1;
              state_reg <= LSP_ACK;
            end else begin
              state_reg <= LSP_IDLE;
            end
          end
        end
        LSP_ACK: if (scl_fall) begin
          bit_reg <= 4'h0;
          if (rw_reg) begin
            shift_reg <= rd_byte;
            sda_oe <= ~rd_byte[7];
            state_reg <= LSP_RBYTE;
          end else begin
            sda_oe <= 1'b0;
            state_reg <= LSP_WBYTE;
          end
        end
        LSP_WBYTE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_in};
            bit_reg <= bit_reg + 4'h1;
          end else if (wr_byte_done) begin
            sda_oe <= 1'b1;
            state_reg <= LSP_ACK;
            if (!have_cmd_reg) begin
              cmd_reg <= shift_reg;
              have_cmd_reg <= 1'b1;
            end else begin
              unique case (wr_cmd)
                LSP_CMD_CONF_A: conf_a_reg <= shift_reg;
                LSP_CMD_CONF_B: conf_b_reg <= shift_reg;
                LSP_CMD_WH_L: wh_l_reg <= shift_reg;
                LSP_CMD_WH_H: wh_h_reg <= shift_reg;
                LSP_CMD_WL_L: wl_l_reg <= shift_reg;
                LSP_CMD_WL_H: wl_h_reg <= shift_reg;
                default: ;
              endcase
              byte_hi_reg <= ~byte_hi_reg;
            end
          end
        end
        LSP_RBYTE: if (scl_fall) begin
          if (bit_reg == 4'h7) begin
            sda_oe <= 1'b0;
            bit_reg <= 4'h0;
            state_reg <= LSP_RACK;
          end else begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe <= ~shift_reg[6];
            bit_reg <= bit_reg + 4'h1;
          end
        end
        LSP_RACK: if (scl_rise) begin
          if (sda_in) begin
            state_reg <= LSP_IDLE;
          end else begin
            byte_hi_reg <= ~byte_hi_reg;
            state_reg <= LSP_ACK;
          end
        end
        default: state_reg <= LSP_IDLE;
      endcase
    end
  end

  property p_timeout_needs_low;
    @(posedge clk) disable iff (!rst_n)
      $rose(bus_timeout) |-> $past(line_low);
  endproperty
  a_timeout_needs_low: assert property (p_timeout_needs_low)
    else $error("timeout without low line");

  property p_timeout_clear;
    @(posedge clk) disable iff (!rst_n)
      !line_low |=> !bus_timeout;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear)
    else $error("timeout stuck after release");

  property p_hold_in_sd;
    @(posedge clk) disable iff (!rst_n)
      shut_down |=> $stable(light_hold_reg);
  endproperty
  a_hold_in_sd: assert property (p_hold_in_sd)
    else $error("result changed in shutdown");

  property p_core_pd;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> core_power_down == $past(conf_a_reg[0]);
  endproperty
  a_core_pd: assert property (p_core_pd)
    else $error("core power down mismatch");

  property p_chan_pd;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> channel_power_down == $past(conf_b_reg[7]);
  endproperty
  a_chan_pd: assert property (p_chan_pd)
    else $error("channel power down mismatch");

  property p_ack_addr;
    @(posedge clk) disable iff (!rst_n)
      state_reg == LSP_ADDR && scl_fall && bit_reg == 4'h8 && !stop_cond
      && !start_cond && !bus_timeout && addr_match |=> sda_oe;
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("matched address not acked");

  property p_nack_other;
    @(posedge clk) disable iff (!rst_n)
      state_reg == LSP_ADDR && scl_fall && bit_reg == 4'h8 && !addr_match
      |=> state_reg == LSP_IDLE && !sda_oe;
  endproperty
  a_nack_other: assert property (p_nack_other)
    else $error("drove bus for foreign address");

  property p_reserved_ignored;
    @(posedge clk) disable iff (!rst_n)
      wr_byte_done && have_cmd_reg && (wr_cmd[7:1] == 7'h01 || wr_cmd > 8'h07)
      |=> $stable({conf_a_reg, conf_b_reg, wh_l_reg, wh_h_reg, wl_l_reg,
      wl_h_reg});
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored)
    else $error("reserved write changed a register");

  c_write: cover property (@(posedge clk) wr_byte_done && have_cmd_reg);
  c_read: cover property (@(posedge clk) state_reg == LSP_RACK);
  c_timeout: cover property (@(posedge clk) $rose(bus_timeout));
  c_sd_read: cover property (@(posedge clk) shut_down && state_reg == LSP_RBYTE);
endmodule
`default_nettype wire

// ---- design/lsp_pkg.sv ----
package lsp_pkg;
  localparam logic [6:0] LSP_ADDR_A = 7'h29;
  localparam logic [6:0] LSP_ADDR_B = 7'h10;
  localparam logic [7:0] LSP_CMD_CONF_A = 8'h00;
  localparam logic [7:0] LSP_CMD_CONF_B = 8'h01;
  localparam logic [7:0] LSP_CMD_WH_L = 8'h04;
  localparam logic [7:0] LSP_CMD_WH_H = 8'h05;
  localparam logic [7:0] LSP_CMD_WL_L = 8'h06;
  localparam logic [7:0] LSP_CMD_WL_H = 8'h07;
  localparam logic [7:0] LSP_CMD_LIGHT_L = 8'h10;
  localparam logic [7:0] LSP_CMD_LIGHT_H = 8'h11;
  localparam logic [7:0] LSP_CMD_IR_L = 8'h12;
  localparam logic [7:0] LSP_CMD_IR_H = 8'h13;
  localparam logic [7:0] LSP_CMD_ID_L = 8'h14;
  localparam logic [7:0] LSP_CMD_ID_H = 8'h15;
  localparam logic [7:0] LSP_CMD_EVENT = 8'h17;
  localparam logic [7:0] LSP_CONF_A_RESET = 8'h01;
  localparam logic [7:0] LSP_CONF_B_RESET = 8'h00;
  // Identity bytes: arbitrary values, tied to no product
  localparam logic [7:0] LSP_ID_LOW = 8'h5C;
  localparam logic [7:0] LSP_ID_HIGH = 8'h0A;
  localparam int LSP_BIT_CORE_PD = 0;
  localparam int LSP_BIT_CHAN_PD = 7;
  localparam int LSP_CLK_HZ = 40000000;
  localparam int LSP_TIMEOUT_MIN_MS = 25;
  localparam int LSP_TIMEOUT_MAX_MS = 35;
  localparam int LSP_TIMEOUT_CYC = LSP_CLK_HZ / 1000 * LSP_TIMEOUT_MIN_MS;
  typedef enum logic [2:0] {
    LSP_IDLE = 3'b000,
    LSP_ADDR = 3'b001,
    LSP_ACK = 3'b010,
    LSP_WBYTE = 3'b011,
    LSP_RBYTE = 3'b100,
    LSP_RACK = 3'b101
  } lsp_state_t;
endpackage

// ---- testbench/light_sensor_i2c_slave_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module light_sensor_i2c_slave_port_test;
  import lsp_pkg::*;
  localparam int TO_CYC = 5000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire scl;
  wire sda;
  wire oe_a;
  wire oe_b;
  wire out_a;
  wire out_b;
  wire core_pd;
  wire chan_pd;
  wire tout;
  logic [15:0] light = 16'h0000;
  logic [15:0] ir = 16'h0000;
  logic valid = 1'b0;
  int errors = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  // Device pulls low only while enabled and driving a zero
  lsp_host_model u_host (.clk(clk),
    .dev_pull((oe_a & ~out_a) | (oe_b & ~out_b)), .scl(scl), .sda(sda));
  lsp_i2c_target #(.ADDR_VARIANT(1'b0), .TIMEOUT_CYC(TO_CYC)) u_dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(out_a),
    .sda_oe(oe_a), .light_result(light), .ir_result(ir),
    .result_valid(valid), .event_flags(8'hC3), .core_power_down(core_pd),
    .channel_power_down(chan_pd), .bus_timeout(tout));
  // Second variant shares the bus, so it must stay quiet for 0x29
  lsp_i2c_target #(.ADDR_VARIANT(1'b1), .TIMEOUT_CYC(TO_CYC)) u_dut_b (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(out_b),
    .sda_oe(oe_b), .light_result(light), .ir_result(ir),
    .result_valid(valid), .event_flags(8'hC3), .core_power_down(),
    .channel_power_down(), .bus_timeout());
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic probe(input logic [7:0] dev, output logic [15:0] a);
    logic [7:0] rx;
    a = 16'h0;
    u_host.start();
    u_host.xfer(dev, 1'b1, rx, a[0]);
    u_host.stop();
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] lo,
                    input logic [7:0] hi);
    logic [7:0] rx;
    logic [15:0] a;
    a = 16'h0;
    u_host.start();
    u_host.xfer(8'h52, 1'b1, rx, a[0]);
    u_host.xfer(cmd, 1'b1, rx, a[1]);
    u_host.xfer(lo, 1'b1, rx, a[2]);
    u_host.xfer(hi, 1'b1, rx, a[3]);
    u_host.stop();
    check("write acks", a, 16'h0000);
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic [7:0] rx;
    logic [15:0] a;
    logic nk;
    a = 16'h0;
    u_host.start();
    u_host.xfer(8'h52, 1'b1, rx, a[0]);
    u_host.xfer(cmd, 1'b1, rx, a[1]);
    u_host.start();
    u_host.xfer(8'h53, 1'b1, rx, a[2]);
    u_host.xfer(8'hFF, 1'b0, d[7:0], nk);
    u_host.xfer(8'hFF, 1'b1, d[15:8], nk);
    u_host.stop();
    check("read acks", a, 16'h0000);
  endtask
  task automatic pulse();
    @(negedge clk) valid = 1'b1;
    @(negedge clk) valid = 1'b0;
  endtask
  task automatic t_reset();
    logic [15:0] d;
    check("core power down", {15'h0, core_pd}, 16'h0001);
    check("channel power down", {15'h0, chan_pd}, 16'h0000);
    check("sda drive level", {15'h0, out_a}, 16'h0000);
    rd(8'h00, d);
    check("config reset", d, 16'h0001);
    rd(8'h04, d);
    check("threshold reset", d, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_addr();
    logic [15:0] a;
    probe(8'h20, a);
    check("second variant ack", a, 16'h0000);
    probe(8'h54, a);
    check("foreign address", a, 16'h0001);
    $display("test address done");
  endtask
  task automatic t_config();
    logic [15:0] d;
    wr(8'h00, 8'h00, 8'h80);
    check("core power down", {15'h0, core_pd}, 16'h0000);
    check("channel power down", {15'h0, chan_pd}, 16'h0001);
    rd(8'h00, d);
    check("config pair", d, 16'h8000);
    wr(8'h00, 8'h00, 8'h00);
    check("channel power up", {15'h0, chan_pd}, 16'h0000);
    // Pair straddles two threshold registers
    wr(8'h05, 8'h5A, 8'hA5);
    rd(8'h05, d);
    check("threshold pair", d, 16'hA55A);
    $display("test config done");
  endtask
  task automatic t_result();
    logic [15:0] d;
    light = 16'hA55A;
    ir = 16'h3CC3;
    pulse();
    wr(8'h10, 8'h00, 8'h00);
    rd(8'h10, d);
    check("light result", d, 16'hA55A);
    rd(8'h12, d);
    check("ir result", d, 16'h3CC3);
    wr(8'h00, 8'h01, 8'h80);
    light = 16'h1234;
    pulse();
    rd(8'h10, d);
    check("held result", d, 16'hA55A);
    check("shutdown", {15'h0, core_pd}, 16'h0001);
    $display("test result done");
  endtask
  task automatic t_reserved();
    logic [15:0] d;
    wr(8'h02, 8'hFF, 8'hFF);
    rd(8'h02, d);
    check("reserved 02", d, 16'h0000);
    rd(8'h08, d);
    check("reserved 08", d, 16'h0000);
    rd(8'h0E, d);
    check("reserved 0E", d, 16'h0000);
    rd(8'h16, d);
    check("reserved 16 and event", d, 16'hC300);
    rd(8'h14, d);
    check("identity", d, {LSP_ID_HIGH, LSP_ID_LOW});
    $display("test reserved done");
  endtask
  task automatic t_timeout();
    logic [15:0] a;
    u_host.scl_low(TO_CYC - 50);
    check("early timeout", {15'h0, tout}, 16'h0000);
    u_host.scl_low(100);
    check("timeout", {15'h0, tout}, 16'h0001);
    u_host.stop();
    probe(8'h52, a);
    check("ack after timeout", a, 16'h0000);
    $display("test timeout done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_addr();
    t_config();
    t_result();
    t_reserved();
    t_timeout();
    stop_test();
  end
  // Tests take about 88k cycles; limit keeps a hang under 100k
  initial begin
    repeat (96000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// ---- testbench/lsp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model #(
  parameter int QTR = 25
) (
  input wire logic clk,
  input wire logic dev_pull,
  output logic scl,
  output logic sda
);
  logic host_sda;
  // Pull-up wins unless someone pulls low
  assign sda = host_sda & ~dev_pull;
  initial begin
    scl = 1'b1;
    host_sda = 1'b1;
  end
  // Four quarters of 25 cycles give 400 kHz
  task automatic wait_q();
    repeat (QTR) @(negedge clk);
  endtask
  task automatic start();
    host_sda = 1'b1;
    wait_q();
    scl = 1'b1;
    wait_q();
    host_sda = 1'b0;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask
  task automatic stop();
    host_sda = 1'b0;
    wait_q();
    scl = 1'b1;
    wait_q();
    host_sda = 1'b1;
    wait_q();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    host_sda = b;
    wait_q();
    scl = 1'b1;
    wait_q();
    r = sda;
    wait_q();
    scl = 1'b0;
    wait_q();
  endtask
  // MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(ack_in, ack);
  endtask
  task automatic scl_low(input int n);
    scl = 1'b0;
    repeat (n) @(negedge clk);
  endtask
endmodule
`default_nettype wire
